// >>> logic/dmc_device.sv
// Operation
// - Route one of eight inputs by address.
// - Latch falling edge captures address when enabled.
// - Latch low holds previous channel address.
// - Deselect high disconnects all eight inputs.
// - Host need not hold address after start.
// - Host should not change address during conversion.
// - Start enables conversion clock, clears SAR.
// - Running conversion ignores further start conditions.
// - New result hidden until conversion completes.
// - End flag stops clock, busy low, reads allowed.
// - Last of three start conditions starts conversion.
// - Host sets other conditions 50ns beforehand.
// - Host holds read/convert low 50ns minimum.
// - Read/convert low keeps data outputs floating.
// - Busy rises within 200ns, stays high.
// - Result latched 500ns before busy falls.
// - Drivers enabled only under four read conditions.
// - Host establishes read conditions 50ns before sampling.
// - Result returned as upper byte, lower nibble.
// - Select low gives MSBs, high gives LSBs.
// - Nibble change shows other part within 50ns.
// - Conversion finishes within 8.1 microseconds.
// - Offset binary, high level means one.
`default_nettype none
module dmc_device
    import dmc_pkg::*;
#(
    parameter int CONV_LEN = dmc_pkg::CONV_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Pin side.
    dmc_if.device pins,
    // Analog sample source and mux control.
    input wire logic [11:0] sample_code,
    output logic [2:0] channel_sel,
    output logic channel_connect,
    output logic conversion_clock_en
);
    import dmc_pkg::*;

    // Three-stage synchronisers for the asynchronous control pins.
    // They reset to the idle pin levels, so no false edge follows reset.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] level;
    assign raw = {pins.read_convert, pins.chip_select_n, pins.chip_enable,
                  pins.channel_addr_bit2, pins.channel_addr_bit1,
                  pins.channel_addr_bit0, pins.addr_latch,
                  pins.mux_deselect};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
            s3 <= PIN_IDLE;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts only once the second and third stages agree.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            level <= PIN_IDLE;
        end else begin
            for (int i = 0; i < NSYNC; i++) begin
                if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    end

    logic rc;
    logic cs_n;
    logic ce;
    logic [2:0] addr;
    logic latch;
    logic desel;
    assign rc = level[7];
    assign cs_n = level[6];
    assign ce = level[5];
    assign addr = level[4:2];
    assign latch = level[1];
    assign desel = level[0];

    // Multiplexer address latch.
    logic latch_prev;
    logic [2:0] chan;
    logic deselected;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latch_prev <= 1'b1;
            chan <= ADDR_RESET;
            deselected <= 1'b1;
        end else begin
            latch_prev <= latch;
            if (latch_prev && !latch) begin
                deselected <= desel;
                if (!desel) begin
                    chan <= addr;
                end
            end
            // Otherwise the address is held whatever the bus shows.
        end
    end
    assign channel_sel = chan;
    assign channel_connect = !deselected;

    // Start is the rising of the combined condition, whichever input
    // arrived last, including simultaneous changes.
    logic start_cond;
    logic start_prev;
    logic start;
    assign start_cond = !rc && !cs_n && ce;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= start_cond;
        end
    end
    assign start = start_cond && !start_prev;

    // Conversion sequencer.
    dmc_state_t state;
    logic [15:0] count;
    logic [3:0] bit_idx;
    logic [11:0] sar;
    logic [11:0] result;
    logic end_flag;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= DMC_IDLE;
            count <= '0;
            bit_idx <= '0;
            sar <= RESULT_RESET;
            end_flag <= 1'b0;
        end else begin
            end_flag <= 1'b0;
            case (state)
                DMC_IDLE: begin
                    if (start) begin
                        state <= DMC_SAR;
                        sar <= RESULT_RESET;
                        count <= '0;
                        bit_idx <= 4'(RESULT_BITS - 1);
                    end
                end
                DMC_SAR: begin
                    // Starts are not looked at here, so none can abort.
                    count <= count + 16'h0001;
                    if (count[3:0] == 4'(BIT_CYCLES - 1) ||
                        count == 16'(CONV_LEN - 1)) begin
                        // Each bit is copied straight from the offset-binary code.
                        sar[bit_idx] <= sample_code[bit_idx];
                    end
                    if (count == 16'(CONV_LEN - RESULT_LEAD_CYCLES - 1)) begin
                        state <= DMC_HOLD;
                        sar <= sample_code;
                    end else if (count[3:0] == 4'(BIT_CYCLES - 1)) begin
                        bit_idx <= bit_idx - 4'h1;
                    end
                end
                DMC_HOLD: begin
                    count <= count + 16'h0001;
                    // The flag ends the conversion one clock after it rises.
                    if (end_flag) begin
                        state <= DMC_IDLE;
                    end else if (count == 16'(CONV_LEN - 2)) begin
                        end_flag <= 1'b1;
                    end
                end
                default: begin
                    state <= DMC_IDLE;
                end
            endcase
        end
    end

    // The output latch takes the result a full lead before busy falls;
    // until then it still holds the previous conversion.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            result <= RESULT_RESET;
        end else if (state == DMC_SAR &&
                     count == 16'(CONV_LEN - RESULT_LEAD_CYCLES - 1)) begin
            result <= sample_code;
        end
    end

    assign pins.busy = (state != DMC_IDLE);
    assign conversion_clock_en = (state != DMC_IDLE);

    // Drive enable and nibble mux follow the pins directly: through the
    // synchroniser they would lag up to 160 ns, past the float and nibble
    // delays. Only the result itself comes from flip-flops.
    logic read_ok;
    assign read_ok = pins.read_convert && !pins.busy && pins.chip_enable &&
                     !pins.chip_select_n;
    assign pins.data_out = pins.nibble_select ? {8'h00, result[3:0]}
                                              : {4'h0, result[11:4]};
    assign pins.data_oe = read_ok ? 12'hFFF : 12'h000;
endmodule
`default_nettype wire

// >>> logic/dmc_pkg.sv
`default_nettype none
package dmc_pkg;
    localparam int CLOCK_MHZ = 25;
    localparam int CLOCK_PERIOD_NS = 40;
    // Conversion time limit in nanoseconds.
    localparam int CONV_MAX_NS = 8100;
    localparam int CONV_MAX_CYCLES = CONV_MAX_NS / CLOCK_PERIOD_NS;
    // Busy rise limit in nanoseconds.
    localparam int BUSY_RISE_NS = 200;
    localparam int BUSY_RISE_CYCLES = BUSY_RISE_NS / CLOCK_PERIOD_NS;
    // Result lead before busy falls, least time.
    localparam int RESULT_LEAD_NS = 500;
    localparam int RESULT_LEAD_CYCLES =
        (RESULT_LEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // Host setup and pulse width, least time.
    localparam int HOST_SETUP_NS = 50;
    localparam int HOST_SETUP_CYCLES =
        (HOST_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RESULT_BITS = 12;
    localparam int UPPER_BITS = 8;
    localparam int LOWER_BITS = 4;
    localparam int CHANNELS = 8;
    localparam int ADDR_BITS = 3;
    // Idle pin levels: read/convert, chip select and latch high.
    localparam logic [7:0] PIN_IDLE = 8'hC2;
    localparam logic [2:0] ADDR_RESET = 3'h0;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // Cycles spent resolving the first successive-approximation bit; later bits take 16.
    localparam int BIT_CYCLES = 10;
    localparam int CONV_CYCLES = RESULT_BITS * BIT_CYCLES + RESULT_LEAD_CYCLES;
    typedef enum logic [2:0] {
        DMC_IDLE = 3'b001,
        DMC_SAR = 3'b010,
        DMC_HOLD = 3'b100
    } dmc_state_t;
endpackage
`default_nettype wire

// >>> logic/dmc_if.sv
`default_nettype none
interface dmc_if;
    import dmc_pkg::*;
    logic read_convert;
    logic chip_select_n;
    logic chip_enable;
    logic nibble_select;
    logic channel_addr_bit0;
    logic channel_addr_bit1;
    logic channel_addr_bit2;
    logic addr_latch;
    logic mux_deselect;
    logic busy;
    logic [11:0] data_out;
    logic [11:0] data_oe;
    modport device (
        input read_convert, chip_select_n, chip_enable, nibble_select,
        input channel_addr_bit0, channel_addr_bit1, channel_addr_bit2,
        input addr_latch, mux_deselect,
        output busy, data_out, data_oe
    );
    modport host (
        output read_convert, chip_select_n, chip_enable, nibble_select,
        output channel_addr_bit0, channel_addr_bit1, channel_addr_bit2,
        output addr_latch, mux_deselect,
        input busy, data_out, data_oe
    );
endinterface
`default_nettype wire

// >>> logic/dmc_host.sv
`default_nettype none
module dmc_host
    import dmc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Pin side.
    dmc_if.host pins,
    // User side.
    input wire logic req_valid,
    input wire logic [2:0] req_channel,
    output logic req_ready,
    output logic [11:0] rsp_data,
    output logic rsp_valid
);
    import dmc_pkg::*;

    typedef enum logic [6:0] {
        DMH_IDLE = 7'b0000001,
        DMH_ADDR = 7'b0000010,
        DMH_LATCH = 7'b0000100,
        DMH_CONV = 7'b0001000,
        DMH_WAIT = 7'b0010000,
        DMH_RDHI = 7'b0100000,
        DMH_RDLO = 7'b1000000
    } dmh_state_t;

    localparam int WAIT_LEN = 4 * HOST_SETUP_CYCLES + 8;

    dmh_state_t state;
    logic [7:0] timer;
    logic s1;
    logic s2;
    logic s3;
    logic busy_seen;
    logic [11:0] dq1;
    logic [11:0] dq2;
    logic [11:0] dq3;

    // Busy and data arrive from another device, so they pass three stages.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            busy_seen <= 1'b0;
            dq1 <= '0;
            dq2 <= '0;
            dq3 <= '0;
        end else begin
            s1 <= pins.busy;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                busy_seen <= s3;
            end
            dq1 <= pins.data_out;
            dq2 <= dq1;
            dq3 <= dq2;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= DMH_IDLE;
            timer <= '0;
            pins.read_convert <= 1'b1;
            pins.chip_select_n <= 1'b1;
            pins.chip_enable <= 1'b0;
            pins.nibble_select <= 1'b0;
            pins.channel_addr_bit0 <= 1'b0;
            pins.channel_addr_bit1 <= 1'b0;
            pins.channel_addr_bit2 <= 1'b0;
            pins.addr_latch <= 1'b1;
            pins.mux_deselect <= 1'b0;
            rsp_data <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            timer <= timer + 8'h01;
            case (state)
                DMH_IDLE: begin
                    timer <= '0;
                    if (req_valid) begin
                        {pins.channel_addr_bit2, pins.channel_addr_bit1,
                         pins.channel_addr_bit0} <= req_channel;
                        pins.addr_latch <= 1'b1;
                        state <= DMH_ADDR;
                    end
                end
                DMH_ADDR: begin
                    if (timer == 8'(WAIT_LEN)) begin
                        pins.addr_latch <= 1'b0;
                        pins.chip_select_n <= 1'b0;
                        pins.chip_enable <= 1'b1;
                        timer <= '0;
                        state <= DMH_LATCH;
                    end
                end
                DMH_LATCH: begin
                    // Other two conditions are set well ahead of the edge.
                    if (timer == 8'(WAIT_LEN)) begin
                        pins.read_convert <= 1'b0;
                        timer <= '0;
                        state <= DMH_CONV;
                    end
                end
                DMH_CONV: begin
                    // Address is left alone for the whole conversion.
                    if (timer == 8'(WAIT_LEN)) begin
                        pins.read_convert <= 1'b1;
                        pins.addr_latch <= 1'b1;
                        timer <= '0;
                        state <= DMH_WAIT;
                    end
                end
                DMH_WAIT: begin
                    if (!busy_seen && timer > 8'(WAIT_LEN)) begin
                        timer <= '0;
                        pins.nibble_select <= 1'b0;
                        state <= DMH_RDHI;
                    end
                    if (timer == 8'hFF) begin
                        timer <= 8'hFF;
                    end
                end
                DMH_RDHI: begin
                    // Read conditions settle before the data is taken.
                    if (timer == 8'(WAIT_LEN)) begin
                        rsp_data[11:4] <= dq3[7:0];
                        pins.nibble_select <= 1'b1;
                        timer <= '0;
                        state <= DMH_RDLO;
                    end
                end
                DMH_RDLO: begin
                    if (timer == 8'(WAIT_LEN)) begin
                        rsp_data[3:0] <= dq3[3:0];
                        rsp_valid <= 1'b1;
                        pins.chip_select_n <= 1'b1;
                        pins.chip_enable <= 1'b0;
                        pins.nibble_select <= 1'b0;
                        state <= DMH_IDLE;
                    end
                end
                default: begin
                    state <= DMH_IDLE;
                end
            endcase
        end
    end

    assign req_ready = (state == DMH_IDLE);
endmodule
`default_nettype wire

// >>> tb/dmc_asserts.sv
`default_nettype none
module dmc_asserts
    import dmc_pkg::*;
#(
    parameter int CONV_LEN = dmc_pkg::CONV_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Host controls.
    input wire logic read_convert,
    input wire logic chip_select_n,
    input wire logic chip_enable,
    input wire logic nibble_select,
    // Device outputs.
    input wire logic busy,
    input wire logic [11:0] data_out,
    input wire logic [11:0] data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // A counter keeps the length check free of long repetitions.
    int busy_cnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busy_cnt <= 0;
        end else if (busy) begin
            busy_cnt <= busy_cnt + 1;
        end else begin
            busy_cnt <= 0;
        end
    end
    a_idle_reset: assert property ($rose(nrst) |-> !busy)
        else $error("busy high right after reset");
    // The start filter takes the whole five-clock rise allowance.
    a_busy_rise: assert property (
        $rose(!read_convert && !chip_select_n && chip_enable) && !busy
        |-> ##[1:5] busy)
        else $error("busy did not follow a start");
    a_busy_len: assert property ($fell(busy) |-> busy_cnt == CONV_LEN)
        else $error("conversion length wrong");
    a_busy_bound: assert property (
        busy |-> busy_cnt < CONV_LEN && busy_cnt < CONV_MAX_CYCLES)
        else $error("conversion ran too long");
    a_oe_busy: assert property (busy |-> data_oe == 12'h000)
        else $error("outputs driven during conversion");
    a_oe_convert: assert property (
        !read_convert |-> data_oe == 12'h000)
        else $error("outputs driven while converting");
    a_oe_deselect: assert property (
        chip_select_n |-> data_oe == 12'h000)
        else $error("outputs driven while deselected");
    a_oe_disable: assert property (
        !chip_enable |-> data_oe == 12'h000)
        else $error("outputs driven while disabled");
    a_oe_whole: assert property (
        data_oe == 12'h000 || data_oe == 12'hFFF)
        else $error("partial output enable");
    a_upper_zero: assert property (data_out[11:8] == 4'h0)
        else $error("unused data bits set");
    a_lower_only: assert property (
        nibble_select |-> data_out[7:4] == 4'h0)
        else $error("lower part carries upper bits");
    c_busy_end: cover property ($fell(busy));
    c_read_upper: cover property (data_oe != 12'h000 && !nibble_select);
    c_read_lower: cover property (data_oe != 12'h000 && nibble_select);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dmc_pkg::*;
    localparam int LEN = 40;
    typedef struct packed {logic [2:0] ch; logic [11:0] code;} dmc_row_t;
    dmc_row_t rows [8] = '{
        '{3'h0, 12'h000}, '{3'h1, 12'hFFF}, '{3'h2, 12'h800},
        '{3'h3, 12'h7FF}, '{3'h4, 12'hA5C}, '{3'h5, 12'h35A},
        '{3'h6, 12'h001}, '{3'h7, 12'hF0E}};
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] req_channel = 3'h0;
    logic [11:0] code = 12'h000;
    logic [11:0] code2 = 12'h9C3;
    logic req_ready, rsp_valid, conn, conn2, clk_en, clk_en2;
    logic [2:0] sel, sel2;
    logic [11:0] rsp_data;
    int n_errors = 0;
    int checks = 0;
    int k, bn, bad;
    dmc_if if1();
    dmc_if if2();
    always #20 clock = ~clock;
    dmc_host dmc_host_i (.clock(clock), .nrst(nrst), .pins(if1.host),
        .req_valid(req_valid), .req_channel(req_channel),
        .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
    dmc_device #(.CONV_LEN(LEN)) dmc_device_i (.clock(clock), .nrst(nrst),
        .pins(if1.device), .sample_code(code), .channel_sel(sel),
        .channel_connect(conn), .conversion_clock_en(clk_en));
    // The second device faces the bench, so misuse can be forced on it.
    dmc_device #(.CONV_LEN(LEN)) dmc_device_i2 (.clock(clock), .nrst(nrst),
        .pins(if2.device), .sample_code(code2), .channel_sel(sel2),
        .channel_connect(conn2), .conversion_clock_en(clk_en2));
    dmc_asserts #(.CONV_LEN(LEN)) dmc_asserts_i (.clock(clock), .nrst(nrst),
        .read_convert(if1.read_convert), .chip_select_n(if1.chip_select_n),
        .chip_enable(if1.chip_enable), .nibble_select(if1.nibble_select),
        .busy(if1.busy), .data_out(if1.data_out), .data_oe(if1.data_oe));
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
end
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Pins pass a filter, so each change is given six clocks to land.
    task automatic put2(input logic rc, cs_n, ce, nib, lat, des,
                        input logic [2:0] a);
        if2.read_convert = rc;
        if2.chip_select_n = cs_n;
        if2.chip_enable = ce;
        if2.nibble_select = nib;
        if2.addr_latch = lat;
        if2.mux_deselect = des;
        {if2.channel_addr_bit2, if2.channel_addr_bit1} = a[2:1];
        if2.channel_addr_bit0 = a[0];
        repeat (6) @(negedge clock);
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        give_verdict();
    end
    initial begin
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
        nrst = 1'b1;
        @(negedge clock);
        `CHK("busy_rst", 1'b0, if2.busy)
        `CHK("oe_rst", 12'h000, if2.data_oe)
        `CHK("conn_rst", 1'b0, conn2)
        foreach (rows[i]) begin
            code = rows[i].code;
            req_channel = rows[i].ch;
            k = 0;
            while (req_ready !== 1'b1 && k < 100) begin
                @(negedge clock);
                k++;
            end
            req_valid = 1'b1;
            @(negedge clock);
            req_valid = 1'b0;
            bn = 0;
            bad = 0;
            k = 0;
            while (rsp_valid !== 1'b1 && k < 2000) begin
                @(negedge clock);
                k++;
                bn += (if1.busy === 1'b1);
                bad += (clk_en !== if1.busy);
            end
            `CHK("rsp_data", rows[i].code, rsp_data)
            `CHK("busy_len", LEN, bn)
            `CHK("clk_en", 0, bad)
            `CHK("chan", rows[i].ch, sel)
            `CHK("connect", 1'b1, conn)
        end
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h5);
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h5);
        `CHK("sel5", 3'h5, sel2)
        `CHK("conn5", 1'b1, conn2)
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2);
        `CHK("held", 3'h5, sel2)
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h6);
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h6);
        `CHK("desel", 1'b0, conn2)
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h3);
        put2(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h3);
        `CHK("sel3", 3'h3, sel2)
        // Chip enable is the last of the three start conditions here.
        put2(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h3);
        if2.chip_enable = 1'b1;
        k = 0;
        while (if2.busy !== 1'b1 && k < 10) begin
            @(negedge clock);
            k++;
        end
        `CHK("rise", 1'b1, k <= BUSY_RISE_CYCLES)
        bn = 0;
        bad = 0;
        while (if2.busy === 1'b1 && bn < 1000) begin
            if2.read_convert = (bn >= 10 && bn < 16);
            bad += (if2.data_oe !== 12'h000);
            @(negedge clock);
            bn++;
        end
        `CHK("len2", LEN, bn)
        `CHK("oe_busy", 0, bad)
        // Address lines may move freely once the channel is latched.
        if2.channel_addr_bit2 = 1'b1;
        repeat (6) @(negedge clock);
        `CHK("no_restart", 1'b0, if2.busy)
        `CHK("addr_free", 3'h3, sel2)
        `CHK("float", 12'h000, if2.data_oe)
        put2(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h3);
        `CHK("oe_on", 12'hFFF, if2.data_oe)
        `CHK("upper", {4'h0, code2[11:4]}, if2.data_out)
        // The other part must show half a clock after the select moves.
        if2.nibble_select = 1'b1;
        @(posedge clock);
        `CHK("lower_fast", {8'h00, code2[3:0]}, if2.data_out)
        @(negedge clock);
        put2(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h3);
        `CHK("lower", {8'h00, code2[3:0]}, if2.data_out)
        put2(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h3);
        `CHK("oe_ce", 12'h000, if2.data_oe)
        put2(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h3);
        `CHK("oe_cs", 12'h000, if2.data_oe)
        give_verdict();
    end
endmodule
`default_nettype wire
